// [core/d3c_host.sv]
// Memory controller end: drives clock, commands, write data; takes read data
`timescale 1ns/1ns
`include "d3c_cfg.svh"
module d3c_host
  import d3c_pkg::*;
#(
  parameter int BA_W   = `D3C_BA_W,
  parameter int COL_W  = `D3C_COL_W,
  parameter int RD_TMO = `D3C_RD_TMO
) (
  input  logic             i_sys_clk,
  input  logic             i_rst,
  d3c_if.host              link,
  input  logic             i_valid,
  input  d3c_cmd_e         i_cmd,
  input  logic [BA_W-1:0]  i_ba,
  input  logic [COL_W-1:0] i_col,
  input  logic [15:0]      i_wdata,
  input  logic [1:0]       i_wmask,
  output logic             o_ready,
  output logic [15:0]      o_rdata,
  output logic             o_rvalid,
  output logic             o_rd_timeout
);
  generate
    if (RD_TMO < 4 || RD_TMO > 65535) begin : g_bad
      $error("d3c_host: unsupported timeout");
    end
  endgenerate

  d3c_host_e        st;
  d3c_host_e        next_st;
  d3c_cmd_e         cmd_q;
  d3c_cmd_e         next_cmd_q;
  logic [BA_W-1:0]  ba_q;
  logic [BA_W-1:0]  next_ba_q;
  logic [COL_W-1:0] col_q;
  logic [COL_W-1:0] next_col_q;
  logic [15:0]      wd_q;
  logic [15:0]      next_wd_q;
  logic [1:0]       wm_q;
  logic [1:0]       next_wm_q;
  logic [15:0]      tmo;
  logic [15:0]      next_tmo;
  logic [2:0]       next_pins;
  logic             next_cs_n;
  logic             next_data_on;
  logic [15:0]      next_rdata;
  logic             next_rvalid;
  logic             next_tmo_ev;
  // Three-stage capture of the device-driven pins
  logic [15:0]      dq_s1, dq_s2, dq_s3;
  logic [1:0]       dqs_s1, dqs_s2, dqs_s3;
  logic [1:0]       rd_lane;

  assign rd_lane = dqs_s2 & dqs_s3;

  always_comb begin
    next_st      = st;
    next_cmd_q   = cmd_q;
    next_ba_q    = ba_q;
    next_col_q   = col_q;
    next_wd_q    = wd_q;
    next_wm_q    = wm_q;
    next_tmo     = tmo;
    next_pins    = {link.ras_n, link.cas_n, link.we_n};
    next_cs_n    = link.cs_n;
    next_data_on = link.dq_h_oe;
    next_rdata   = o_rdata;
    next_rvalid  = 1'b0;
    next_tmo_ev  = 1'b0;
    // Command and data pins move only where the link clock falls, so they settle before its rise
    unique case (st)
      D3C_H_IDLE: begin
        if (i_valid) begin
          next_st    = D3C_H_LOAD;
          next_cmd_q = i_cmd;
          next_ba_q  = i_ba;
          next_col_q = i_col;
          next_wd_q  = i_wdata;
          next_wm_q  = i_wmask;
        end
      end
      D3C_H_LOAD: begin
        if (link.ck) begin
          next_st   = D3C_H_CMD;
          next_cs_n = 1'b0; // No-op also goes out selected
          unique case (cmd_q)
            D3C_CMD_ROW_OPEN: next_pins = `D3C_ENC_ACT;
            D3C_CMD_PRE:      next_pins = `D3C_ENC_PRE;
            D3C_CMD_RD:       next_pins = `D3C_ENC_RD;
            D3C_CMD_WR:       next_pins = `D3C_ENC_WR;
            D3C_CMD_NOP:      next_pins = `D3C_ENC_NOP;
          endcase
        end
      end
      D3C_H_CMD: begin
        if (link.ck) begin
          next_cs_n = 1'b1;
          next_pins = `D3C_ENC_NOP;
          next_tmo  = 16'h0000;
          if (cmd_q == D3C_CMD_WR) begin
            next_st      = D3C_H_WDATA;
            next_data_on = 1'b1;
          end else if (cmd_q == D3C_CMD_RD) begin
            next_st = D3C_H_RWAIT;
          end else begin
            next_st = D3C_H_IDLE;
          end
        end
      end
      D3C_H_WDATA: begin
        if (link.ck) begin
          next_st      = D3C_H_IDLE;
          next_data_on = 1'b0;
        end
      end
      D3C_H_RWAIT: begin
        if (rd_lane != 2'h0) begin
          for (int l = 0; l < 2; l++) begin
            if (rd_lane[l]) begin
              next_rdata[l*8 +: 8] = dq_s3[l*8 +: 8];
            end
          end
          next_rvalid = 1'b1;
          next_st     = D3C_H_RREL;
        end else if (tmo == 16'(RD_TMO - 1)) begin
          next_tmo_ev = 1'b1;
          next_st     = D3C_H_IDLE;
        end else begin
          next_tmo = tmo + 16'h0001;
        end
      end
      D3C_H_RREL: begin
        // Wait for the device to release the strobe before the next command
        if ((dqs_s2 | dqs_s3) == 2'h0) begin
          next_st = D3C_H_IDLE;
        end
      end
      default: next_st = D3C_H_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st            <= D3C_H_IDLE;
      cmd_q         <= D3C_CMD_NOP;
      ba_q          <= '0;
      col_q         <= '0;
      wd_q          <= `D3C_DQ_RST;
      wm_q          <= 2'h0;
      tmo           <= 16'h0000;
      dq_s1         <= `D3C_DQ_RST;
      dq_s2         <= `D3C_DQ_RST;
      dq_s3         <= `D3C_DQ_RST;
      dqs_s1        <= `D3C_STROBE_RST;
      dqs_s2        <= `D3C_STROBE_RST;
      dqs_s3        <= `D3C_STROBE_RST;
      link.ck       <= 1'b0;
      link.cs_n     <= 1'b1;
      link.ras_n    <= 1'b1;
      link.cas_n    <= 1'b1;
      link.we_n     <= 1'b1;
      link.ba       <= '0;
      link.a        <= '0;
      link.dm       <= 2'h0;
      link.dq_h     <= `D3C_DQ_RST;
      link.dq_h_oe  <= 1'b0;
      link.dqs_h    <= `D3C_STROBE_RST;
      link.dqs_n_h  <= 2'h3;
      link.dqs_h_oe <= 1'b0;
      o_ready       <= 1'b0;
      o_rdata       <= `D3C_DQ_RST;
      o_rvalid      <= 1'b0;
      o_rd_timeout  <= 1'b0;
    end else begin
      st            <= next_st;
      cmd_q         <= next_cmd_q;
      ba_q          <= next_ba_q;
      col_q         <= next_col_q;
      wd_q          <= next_wd_q;
      wm_q          <= next_wm_q;
      tmo           <= next_tmo;
      dq_s1         <= link.dq;
      dq_s2         <= dq_s1;
      dq_s3         <= dq_s2;
      dqs_s1        <= link.dqs;
      dqs_s2        <= dqs_s1;
      dqs_s3        <= dqs_s2;
      link.ck       <= ~link.ck; // Divide by two
      link.cs_n     <= next_cs_n;
      {link.ras_n, link.cas_n, link.we_n} <= next_pins;
      link.ba       <= next_ba_q;
      link.a        <= next_col_q;
      link.dm       <= next_data_on ? wm_q : 2'h0;
      link.dq_h     <= next_data_on ? wd_q : `D3C_DQ_RST;
      link.dq_h_oe  <= next_data_on;
      link.dqs_h    <= next_data_on ? 2'h3 : 2'h0;
      link.dqs_n_h  <= next_data_on ? 2'h0 : 2'h3;
      link.dqs_h_oe <= next_data_on;
      o_ready       <= (next_st == D3C_H_IDLE);
      o_rdata       <= next_rdata;
      o_rvalid      <= next_rvalid;
      o_rd_timeout  <= next_tmo_ev;
    end
  end
endmodule // d3c_host

// [core/d3c_cfg.svh]
// Constants for the DDR3 command decode and strobe link
`ifndef D3C_CFG_SVH
`define D3C_CFG_SVH

// Link geometry
`define D3C_BA_W        3
`define D3C_COL_W       2
`define D3C_DQ_W        16
`define D3C_LANES       2
`define D3C_LANE_W      8

// Command pin encodings {ras_n, cas_n, we_n}, chip select low
`define D3C_ENC_ACT     3'h3
`define D3C_ENC_PRE     3'h2
`define D3C_ENC_RD      3'h5
`define D3C_ENC_WR      3'h4
`define D3C_ENC_NOP     3'h7

// Device timing in link clock cycles
`define D3C_PRE_CK      2
`define D3C_RD_HOLD_CK  4

// Host timing in system clock cycles
`define D3C_RD_TMO      64

// Reset values
`define D3C_DQ_RST      16'h0000
`define D3C_STROBE_RST  2'h0

`endif

// [core/d3c_pkg.sv]
// Types shared by both ends of the DDR3 command and strobe link
package d3c_pkg;
  typedef enum logic [2:0] {
    D3C_CMD_NOP,
    D3C_CMD_ROW_OPEN,
    D3C_CMD_PRE,
    D3C_CMD_RD,
    D3C_CMD_WR
  } d3c_cmd_e;

  typedef enum logic [1:0] {
    D3C_BANK_IDLE,
    D3C_BANK_ACTIVE,
    D3C_BANK_CLOSING
  } d3c_bank_e;

  typedef enum logic [2:0] {
    D3C_H_IDLE,
    D3C_H_LOAD,
    D3C_H_CMD,
    D3C_H_WDATA,
    D3C_H_RWAIT,
    D3C_H_RREL
  } d3c_host_e;
endpackage

// [core/d3c_if.sv]
// Pin-level link between memory controller and DDR3 device
`timescale 1ns/1ns
`include "d3c_cfg.svh"
interface d3c_if #(
  parameter int BA_W  = `D3C_BA_W,
  parameter int COL_W = `D3C_COL_W
);
  logic             ck;
  logic             cs_n;
  logic             ras_n;
  logic             cas_n;
  logic             we_n;
  logic [BA_W-1:0]  ba;
  logic [COL_W-1:0] a;
  logic [1:0]       dm;
  logic [15:0]      dq_h;
  logic             dq_h_oe;
  logic [1:0]       dqs_h;
  logic [1:0]       dqs_n_h;
  logic             dqs_h_oe;
  logic [15:0]      dq_d;
  logic             dq_d_oe;
  logic [1:0]       dqs_d;
  logic [1:0]       dqs_n_d;
  logic             dqs_d_oe;
  wire  [15:0]      dq;
  wire  [1:0]       dqs;
  wire  [1:0]       dqs_n;

  // Shared wires; an idle bus shows the host's parked levels, never a float
  assign dq    = dq_d_oe ? dq_d : dq_h;
  assign dqs   = dqs_d_oe ? dqs_d : dqs_h;
  assign dqs_n = dqs_d_oe ? dqs_n_d : dqs_n_h;

  modport host (
    output ck, cs_n, ras_n, cas_n, we_n, ba, a, dm,
    output dq_h, dq_h_oe, dqs_h, dqs_n_h, dqs_h_oe,
    input  dq, dqs, dqs_n
  );
  modport dev (
    input  ck, cs_n, ras_n, cas_n, we_n, ba, a, dm,
    input  dq, dqs, dqs_n,
    output dq_d, dq_d_oe, dqs_d, dqs_n_d, dqs_d_oe
  );
endinterface // d3c_if

// [core/d3c_dev.sv]
// DDR3 device end: command decode, bank states, masked writes, strobed reads
`timescale 1ns/1ns
`include "d3c_cfg.svh"

module d3c_dev
  import d3c_pkg::*;
#(
  parameter int BA_W       = `D3C_BA_W,
  parameter int COL_W      = `D3C_COL_W,
  parameter int PRE_CK     = `D3C_PRE_CK,
  parameter int RD_HOLD_CK = `D3C_RD_HOLD_CK
) (
  input  logic                 i_rst,
  d3c_if.dev                   link,
  output logic [(1<<BA_W)-1:0] o_bank_open,
  output logic                 o_wr_done,
  output logic                 o_rd_done
);
  localparam int BANKS = 1 << BA_W;
  localparam int WORDS = BANKS << COL_W;
  localparam int IDX_W = BA_W + COL_W;

  generate
    if (PRE_CK < 1 || PRE_CK > 255 || RD_HOLD_CK < 1 || RD_HOLD_CK > 255 || COL_W < 1) begin : g_bad
      $error("d3c_dev: unsupported parameter values");
    end
  endgenerate

  d3c_cmd_e         cmd;
  logic [IDX_W-1:0] idx;

  // Decode straight from the pins; all state below registers on the rise
  always_comb begin
    cmd = D3C_CMD_NOP;
    idx = {link.ba, link.a};
    if (!link.cs_n) begin
      unique case ({link.ras_n, link.cas_n, link.we_n})
        `D3C_ENC_ACT: cmd = D3C_CMD_ROW_OPEN;
        `D3C_ENC_PRE: cmd = D3C_CMD_PRE;
        `D3C_ENC_RD:  cmd = D3C_CMD_RD;
        `D3C_ENC_WR:  cmd = D3C_CMD_WR;
        default:      cmd = D3C_CMD_NOP;
      endcase
    end
  end

  // Bank state machines, one per bank
  d3c_bank_e            bank_st [BANKS];
  logic [BANKS-1:0]     bank_act;
  logic [BANKS-1:0]     next_open;

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      d3c_bank_e  next_st;
      logic [7:0] cnt;
      logic [7:0] next_cnt;
      logic       hit;

      assign hit         = (link.ba == BA_W'(b));
      assign bank_act[b] = (bank_st[b] == D3C_BANK_ACTIVE);

      always_comb begin
        next_st  = bank_st[b];
        next_cnt = cnt;
        unique case (bank_st[b])
          D3C_BANK_IDLE: begin
            if (hit && cmd == D3C_CMD_ROW_OPEN) begin
              next_st = D3C_BANK_ACTIVE;
            end
          end
          D3C_BANK_ACTIVE: begin
            if (hit && cmd == D3C_CMD_PRE) begin
              next_st  = D3C_BANK_CLOSING;
              next_cnt = 8'(PRE_CK - 1);
            end
          end
          D3C_BANK_CLOSING: begin
            // Idle only once the precharge time has run out
            if (cnt == 8'h00) begin
              next_st = D3C_BANK_IDLE;
            end else begin
              next_cnt = cnt - 8'h01;
            end
          end
          default: next_st = D3C_BANK_IDLE;
        endcase
        next_open[b] = (next_st == D3C_BANK_ACTIVE);
      end

      always_ff @(posedge link.ck or posedge i_rst) begin
        if (i_rst) begin
          bank_st[b] <= D3C_BANK_IDLE;
          cnt        <= 8'h00;
        end else begin
          bank_st[b] <= next_st;
          cnt        <= next_cnt;
        end
      end
    end
  endgenerate

  // Storage and the data path
  logic [15:0]      mem [WORDS];
  logic [15:0]      next_mem [WORDS];
  logic             wr_pend;
  logic             next_wr_pend;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] next_wr_idx;
  logic [7:0]       rd_cnt;
  logic [7:0]       next_rd_cnt;
  logic [15:0]      next_dq;
  logic [1:0]       next_dqs;
  logic             next_oe;
  logic             next_wr_done;
  logic             next_rd_done;
  logic             bank_ok;

  assign bank_ok = bank_act[link.ba];

  always_comb begin
    next_mem     = mem;
    next_wr_pend = 1'b0;
    next_wr_idx  = wr_idx;
    next_rd_cnt  = rd_cnt;
    next_dq      = link.dq_d;
    next_dqs     = link.dqs_d;
    next_oe      = link.dq_d_oe;
    next_wr_done = 1'b0;
    next_rd_done = 1'b0;

    // Write beat arrives one rise after the write command
    if (wr_pend) begin
      for (int l = 0; l < `D3C_LANES; l++) begin
        // Lane stored only under its own live differential strobe
        if (link.dqs[l] && !link.dqs_n[l] && !link.dm[l]) begin
          next_mem[wr_idx][l*`D3C_LANE_W +: `D3C_LANE_W] = link.dq[l*`D3C_LANE_W +: `D3C_LANE_W];
        end
      end
      next_wr_done = 1'b1;
    end

    if (cmd == D3C_CMD_WR && bank_ok && !wr_pend) begin
      next_wr_pend = 1'b1;
      next_wr_idx  = idx;
    end

    // Read: data and strobe rise together, held for the hold time
    if (rd_cnt != 8'h00) begin
      next_rd_cnt = rd_cnt - 8'h01;
      if (rd_cnt == 8'h01) begin
        next_oe  = 1'b0;
        next_dqs = `D3C_STROBE_RST;
      end
    end else if (cmd == D3C_CMD_RD && bank_ok) begin
      next_dq      = mem[idx];
      next_dqs     = 2'h3;
      next_oe      = 1'b1;
      next_rd_cnt  = 8'(RD_HOLD_CK);
      next_rd_done = 1'b1;
    end
  end

  always_ff @(posedge link.ck or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= `D3C_DQ_RST;
      end
      wr_pend          <= 1'b0;
      wr_idx           <= '0;
      rd_cnt           <= 8'h00;
      link.dq_d        <= `D3C_DQ_RST;
      link.dq_d_oe     <= 1'b0;
      link.dqs_d       <= `D3C_STROBE_RST;
      link.dqs_n_d     <= 2'h3;
      link.dqs_d_oe    <= 1'b0;
      o_bank_open      <= '0;
      o_wr_done        <= 1'b0;
      o_rd_done        <= 1'b0;
    end else begin
      mem              <= next_mem;
      wr_pend          <= next_wr_pend;
      wr_idx           <= next_wr_idx;
      rd_cnt           <= next_rd_cnt;
      link.dq_d        <= next_dq;
      link.dq_d_oe     <= next_oe;
      link.dqs_d       <= next_dqs;
      link.dqs_n_d     <= ~next_dqs;
      link.dqs_d_oe    <= next_oe;
      o_bank_open      <= next_open;
      o_wr_done        <= next_wr_done;
      o_rd_done        <= next_rd_done;
    end
  end
endmodule // d3c_dev

// [testbench/d3c_asserts.sv]
// Link checker: device decode, read strobes and host write beat
`timescale 1ns/1ns
`include "d3c_cfg.svh"
module d3c_asserts #(
  parameter int BA_W = `D3C_BA_W
) (
  input logic                 i_rst,
  input logic                 ck,
  input logic                 cs_n,
  input logic                 ras_n,
  input logic                 cas_n,
  input logic                 we_n,
  input logic [BA_W-1:0]      ba,
  input logic [1:0]           dqs,
  input logic [1:0]           dqs_n,
  input logic                 dq_h_oe,
  input logic                 dqs_h_oe,
  input logic [15:0]          dq_d,
  input logic                 dq_d_oe,
  input logic [1:0]           dqs_d,
  input logic [1:0]           dqs_n_d,
  input logic                 dqs_d_oe,
  input logic [(1<<BA_W)-1:0] o_bank_open
);
  default clocking @(posedge ck); endclocking
  default disable iff (i_rst);
  wire [2:0] cmd = {ras_n, cas_n, we_n};
  wire       sel = !cs_n;
  sequence s_rd_beat;
    dq_d_oe && dqs_d == 2'h3 && dqs_n_d == 2'h0;
  endsequence
  sequence s_wr_beat;
    dq_h_oe && dqs_h_oe && dqs == 2'h3 && dqs_n == 2'h0 && cs_n;
  endsequence
  property p_row_open;
    sel && cmd == `D3C_ENC_ACT |=> o_bank_open[$past(ba)];
  endproperty
  property p_pre;
    sel && cmd == `D3C_ENC_PRE && o_bank_open[ba] |=> !o_bank_open[$past(ba)];
  endproperty
  property p_cs_off;
    cs_n && !dq_d_oe |=> !dq_d_oe && $stable(o_bank_open);
  endproperty
  property p_nop;
    sel && cmd == `D3C_ENC_NOP |=> $stable(o_bank_open);
  endproperty
  // Four held beats, then the lane is let go
  property p_read;
    sel && cmd == `D3C_ENC_RD && o_bank_open[ba] && !dq_d_oe |=> s_rd_beat [*4] ##1 !dq_d_oe;
  endproperty
  property p_rd_hold;
    dq_d_oe && $past(dq_d_oe) |-> $stable(dq_d);
  endproperty
  property p_pair;
    dqs_d_oe || dqs_h_oe |-> dqs_n == ~dqs;
  endproperty
  property p_write;
    sel && cmd == `D3C_ENC_WR |=> s_wr_beat ##1 !dqs_h_oe;
  endproperty
  a_row_open: assert property (p_row_open)
    else $error("row open left bank closed");
  a_pre: assert property (p_pre)
    else $error("precharged bank still open");
  a_cs_off: assert property (p_cs_off)
    else $error("deselected cycle changed device state");
  a_nop: assert property (p_nop)
    else $error("no-op changed bank state");
  a_read: assert property (p_read)
    else $error("read strobe burst malformed");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without strobe edge");
  a_pair: assert property (p_pair)
    else $error("strobe halves not complementary");
  a_write: assert property (p_write)
    else $error("write beat missing after write command");
endmodule // d3c_asserts

// [testbench/testbench.sv]
// Testbench: both link ends joined, driven from the controller user side
`timescale 1ns/1ns
`include "d3c_cfg.svh"
module testbench
  import d3c_pkg::*;
();
  logic        i_sys_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        i_valid   = 1'b0;
  d3c_cmd_e    i_cmd     = D3C_CMD_NOP;
  logic [2:0]  i_ba      = 3'h0;
  logic [1:0]  i_col     = 2'h0;
  logic [15:0] i_wdata   = 16'h0000;
  logic [1:0]  i_wmask   = 2'h0;
  logic        o_ready, o_rvalid, o_rd_timeout, o_wr_done, o_rd_done, got, tmo;
  logic [15:0] o_rdata, rd;
  logic [7:0]  o_bank_open;
  logic [2:0]  pins;
  int          err_total = 0;
  int          comparisons = 0;
  int          wr_pulses = 0;
  int          rd_pulses = 0;
  logic [15:0] wds[3] = '{16'h1234, 16'h5678, 16'hffff};
  logic [15:0] exps[3] = '{16'h12c3, 16'h1278, 16'h1278};

  always #5 i_sys_clk = ~i_sys_clk;

  d3c_if link_if ();
  d3c_host #(.RD_TMO(16)) d3c_host_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link_if.host),
    .i_valid(i_valid), .i_cmd(i_cmd), .i_ba(i_ba), .i_col(i_col), .i_wdata(i_wdata),
    .i_wmask(i_wmask), .o_ready(o_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_rd_timeout(o_rd_timeout));
  d3c_dev d3c_dev_i (.i_rst(i_rst), .link(link_if.dev), .o_bank_open(o_bank_open),
    .o_wr_done(o_wr_done), .o_rd_done(o_rd_done));
  d3c_asserts #(.BA_W(`D3C_BA_W)) d3c_asserts_i (.i_rst(i_rst), .ck(link_if.ck),
    .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
    .ba(link_if.ba), .dqs(link_if.dqs), .dqs_n(link_if.dqs_n), .dq_h_oe(link_if.dq_h_oe),
    .dqs_h_oe(link_if.dqs_h_oe), .dq_d(link_if.dq_d), .dq_d_oe(link_if.dq_d_oe),
    .dqs_d(link_if.dqs_d), .dqs_n_d(link_if.dqs_n_d), .dqs_d_oe(link_if.dqs_d_oe),
    .o_bank_open(o_bank_open));

  // Pin code seen at each rise with chip select low, device pulses at each rise
  always @(posedge link_if.ck) begin
    if (link_if.cs_n === 1'b0) begin
      pins <= {link_if.ras_n, link_if.cas_n, link_if.we_n};
    end
    if (o_wr_done === 1'b1) begin
      wr_pulses++;
    end
    if (o_rd_done === 1'b1) begin
      rd_pulses++;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic seen);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic chk_pins(input logic [2:0] exp);
    chk("pins", {13'h0, exp}, {13'h0, pins});
  endtask

  // One request; a cycle count bounds every wait for ready, read results collected on the way
  task automatic op(input d3c_cmd_e c, input logic [2:0] b, input logic [1:0] col,
                    input logic [15:0] wd, input logic [1:0] wm);
    int n;
    n = 0;
    got = 1'b0;
    tmo = 1'b0;
    do begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end while (o_ready !== 1'b1 && n < 50);
    i_valid = 1'b1;
    i_cmd = c;
    i_ba = b;
    i_col = col;
    i_wdata = wd;
    i_wmask = wm;
    @(posedge i_sys_clk);
    #1 i_valid = 1'b0;
    for (n = 0; n < 60; n++) begin
      @(posedge i_sys_clk);
      #1;
      if (o_rvalid === 1'b1) begin
        got = 1'b1;
        rd = o_rdata;
      end
      if (o_rd_timeout === 1'b1) tmo = 1'b1;
      if (o_ready === 1'b1) break;
    end
    chk_flag("ready", 1'b1, o_ready);
  endtask

  task automatic rd_chk(input logic [2:0] b, input logic [15:0] exp);
    op(D3C_CMD_RD, b, 2'h2, 16'h0000, 2'h0);
    chk_pins(`D3C_ENC_RD);
    chk_flag("rvalid", 1'b1, got);
    chk("rdata", exp, rd);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    repeat (4) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    op(D3C_CMD_NOP, 3'h5, 2'h0, 16'h0000, 2'h0);
    chk_pins(`D3C_ENC_NOP);
    chk("banks", 16'h0000, {8'h00, o_bank_open});
    $display("test nop done");
    op(D3C_CMD_ROW_OPEN, 3'h5, 2'h0, 16'h0000, 2'h0);
    chk_pins(`D3C_ENC_ACT);
    op(D3C_CMD_ROW_OPEN, 3'h0, 2'h0, 16'h0000, 2'h0);
    chk("banks", 16'h0021, {8'h00, o_bank_open});
    $display("test row open done");
    op(D3C_CMD_WR, 3'h5, 2'h2, 16'ha5c3, 2'h0);
    chk_pins(`D3C_ENC_WR);
    rd_chk(3'h5, 16'ha5c3);
    rd_chk(3'h0, 16'h0000);
    $display("test write read done");
    for (int i = 0; i < 3; i++) begin
      op(D3C_CMD_WR, 3'h5, 2'h2, wds[i], 2'(i + 1));
      rd_chk(3'h5, exps[i]);
    end
    $display("test lane mask done");
    op(D3C_CMD_PRE, 3'h5, 2'h0, 16'h0000, 2'h0);
    chk_pins(`D3C_ENC_PRE);
    chk("banks", 16'h0001, {8'h00, o_bank_open});
    op(D3C_CMD_RD, 3'h5, 2'h2, 16'h0000, 2'h0);
    chk_flag("rd_timeout", 1'b1, tmo);
    chk_flag("rvalid", 1'b0, got);
    op(D3C_CMD_ROW_OPEN, 3'h5, 2'h0, 16'h0000, 2'h0);
    chk("banks", 16'h0021, {8'h00, o_bank_open});
    rd_chk(3'h5, 16'h1278);
    // Only accesses to an open bank may pulse the device's done flags
    chk("wr_done pulses", 16'h0004, 16'(wr_pulses));
    chk("rd_done pulses", 16'h0006, 16'(rd_pulses));
    $display("test precharge done");
    stop_test();
  end
endmodule // testbench
